// ==== hdl/hsp_pkg.sv ====
// package of the shared ram host port: widths, register indices, states
// assumes: used by hsp_if, hsp_dev and hsp_host; one 50 MHz clock
package hsp_pkg;
  // ****************************************************************
  // widths and memory
  // ****************************************************************
  localparam int AW        = 16;           // host address width
  localparam int DW        = 16;           // host data width
  localparam int PW        = 17;           // ram word with parity
  localparam int RELOC_W   = 6;            // housekeeping relocation bits
  localparam int HK_SHIFT  = 10;           // housekeeping area is 1k words
  localparam logic [AW-1:0] HK_DEF_BASE = 16'h0000;
  localparam logic [AW-1:0] HK_DEF_LAST = 16'h03ff;
  localparam int CLK_MHZ   = 50;
  // ****************************************************************
  // device registers, word index on the host address bus
  // ****************************************************************
  localparam logic [1:0] DREG_CFG   = 2'h0; // relocation, queue, fast access
  localparam logic [1:0] DREG_STAT  = 2'h1; // sticky events, read clears
  localparam logic [1:0] DREG_MASK  = 2'h2;
  localparam logic [1:0] DREG_PADDR = 2'h3; // last parity error address
  localparam int CFG_QEN    = 6;
  localparam int CFG_FAST   = 7;
  localparam int EV_PARITY  = 0;
  // ****************************************************************
  // host controller registers, wishbone byte offsets
  // ****************************************************************
  localparam logic [4:0] HREG_ADDR  = 5'h00;
  localparam logic [4:0] HREG_WDATA = 5'h04;
  localparam logic [4:0] HREG_CTRL  = 5'h08; // 0 go, 1 read, 2 memory
  localparam logic [4:0] HREG_STAT  = 5'h0c; // 0 done (sticky), 8 busy
  localparam logic [4:0] HREG_MASK  = 5'h10;
  localparam logic [4:0] HREG_RDATA = 5'h14;
  localparam int CTL_GO = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_MEM = 2;
  localparam int ST_BUSY = 8;
  localparam logic STRAP_SHARED = 1'b0;    // shared ram, not dma
  localparam logic STRAP_NOWAIT = 1'b1;    // non-zero wait interface
  localparam logic STRAP_WIDTH  = 1'b1;    // 16-bit
  localparam logic STRAP_POL    = 1'b1;    // high reads
  // ****************************************************************
  // state machines
  // ****************************************************************
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_ADDR = 3'b001, DS_SLIP = 3'b010,
    DS_XFER = 3'b011, DS_DONE = 3'b100
  } hsp_dstate_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_WAIT = 2'b01, HS_END = 2'b10
  } hsp_hstate_e;
endpackage : hsp_pkg

// ==== hdl/hsp_if.sv ====
// pins between the host processor and the terminal's parallel port
// assumes: the bench resolves the shared data bus from the two enables
`timescale 1ns/1ps
interface hsp_if;
  import hsp_pkg::*;
  logic          select_n;
  logic          data_strobe_n;
  logic          mem_reg_sel;        // high ram, low registers
  logic          rd_wr;
  logic [AW-1:0] host_address_bus;
  logic [DW-1:0] host_data_bus;      // resolved level, driven by bench
  logic [DW-1:0] host_data_o;
  logic          host_data_oe;
  logic [DW-1:0] dev_data_o;
  logic          dev_data_oe;
  logic          host_access_active_n;
  logic          transfer_ready_n;
  logic          address_latch_strobe;
  logic          shared_ram_strap;
  logic          no_wait_strap;
  logic          dma_req_or_width_strap;
  logic          polarity_strap;
  logic          int_req_n;
  modport dev (input select_n, data_strobe_n, mem_reg_sel, rd_wr, host_address_bus,
               host_data_bus, address_latch_strobe, shared_ram_strap, no_wait_strap,
               dma_req_or_width_strap, polarity_strap,
               output dev_data_o, dev_data_oe, host_access_active_n, transfer_ready_n,
               int_req_n);
  modport host (output select_n, data_strobe_n, mem_reg_sel, rd_wr, host_address_bus,
                host_data_o, host_data_oe, address_latch_strobe, shared_ram_strap,
                no_wait_strap, dma_req_or_width_strap, polarity_strap,
                input host_data_bus, host_access_active_n, transfer_ready_n, int_req_n);
endinterface : hsp_if

// ==== hdl/hsp_dev.sv ====
// terminal end of the host port: shared parity ram, arbitration, registers
// assumes: host pins synchronous to clk_i; internal logic on the user side
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module hsp_dev
  import hsp_pkg::*;
#(
  parameter int RAM_AW = 16
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  hsp_if.dev                     pins,
  input  wire logic              sync_slip_i,   // host edges missed setup window
  input  wire logic              rt_mon_mode_i, // rt or selective monitor mode
  input  wire logic              int_req_i,     // internal logic ram request
  input  wire logic              int_we_i,
  input  wire logic [AW-1:0]     int_addr_i,
  input  wire logic [DW-1:0]     int_wdata_i,
  output logic                   int_ack_o,
  output logic [DW-1:0]          int_rdata_o,
  output logic                   queue_wr_o,    // interrupt status queue entry
  output logic [AW-1:0]          queue_addr_o,
  output logic [AW-1:0]          hk_base_o,     // housekeeping area base
  output logic                   int_o
);
  // ****************************************************************
  // state and storage
  // ****************************************************************
  logic [PW-1:0]       ram [0:(1<<RAM_AW)-1];
  hsp_dstate_e         state_r;
  logic                is_mem_r;
  logic                is_rd_r;
  logic [AW-1:0]       addr_r;
  logic [DW-1:0]       dout_r;
  logic                oe_r;
  logic                active_n_r;
  logic                ready_n_r;
  logic [7:0]          cfg_r;
  logic [7:0]          stat_r;
  logic [7:0]          mask_r;
  logic [AW-1:0]       paddr_r;
  logic                host_req;
  logic                int_gnt;
  logic                host_ram;
  logic                host_rd;
  logic [RAM_AW-1:0]   h_idx;
  logic [RAM_AW-1:0]   i_idx;
  logic [PW-1:0]       h_word;
  logic [PW-1:0]       i_word;
  logic                h_perr;
  logic                i_perr;
  logic                perr;

  // ****************************************************************
  // arbitration and decode
  // ****************************************************************
  assign host_req = !pins.select_n && !pins.data_strobe_n;
  // internal logic yields to a waiting host when fast access is on
  // a request still held on its ack cycle is not granted a second time
  assign int_gnt  = ce_i && int_req_i && !int_ack_o && state_r != DS_XFER &&
                    !(cfg_r[CFG_FAST] && host_req && state_r == DS_IDLE);
  assign host_ram = ce_i && state_r == DS_XFER && is_mem_r;
  assign host_rd  = (pins.rd_wr == pins.polarity_strap);
  assign h_idx    = addr_r[RAM_AW-1:0];
  assign i_idx    = int_addr_i[RAM_AW-1:0];
  assign h_word   = ram[h_idx];
  assign i_word   = ram[i_idx];
  // even parity over the stored word, checked on both readers
  assign h_perr   = host_ram && is_rd_r && (^h_word);
  assign i_perr   = int_gnt && !int_we_i && (^i_word);
  assign perr     = h_perr || i_perr;

  // ****************************************************************
  // host transfer sequencer
  // ****************************************************************
  // no master port exists: every access here is answered, none started
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= DS_IDLE;
      active_n_r <= 1'b1;
      ready_n_r  <= 1'b1;
      oe_r       <= 1'b0;
      is_mem_r   <= 1'b0;
      is_rd_r    <= 1'b0;
      addr_r     <= '0;
    end else if (ce_i) begin
      case (state_r)
        DS_IDLE: begin
          // start only when no internal access holds the ram this cycle
          if (host_req && !int_gnt) begin
            active_n_r <= 1'b0;
            is_mem_r   <= pins.mem_reg_sel;
            is_rd_r    <= host_rd;
            state_r    <= sync_slip_i ? DS_SLIP : DS_ADDR;
          end
        end
        DS_SLIP: begin
          state_r <= DS_ADDR;
        end
        DS_ADDR: begin
          addr_r  <= pins.host_address_bus;
          state_r <= DS_XFER;
        end
        DS_XFER: begin
          ready_n_r <= 1'b0;
          oe_r      <= is_rd_r;
          state_r   <= DS_DONE;
        end
        DS_DONE: begin
          // strobe release ends the cycle; select may already be high
          if (pins.data_strobe_n) begin
            ready_n_r  <= 1'b1;
            active_n_r <= 1'b1;
            oe_r       <= 1'b0;
            state_r    <= DS_IDLE;
          end
        end
        default: state_r <= DS_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // shared ram with parity generation
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (host_ram && !is_rd_r) begin
      ram[h_idx] <= {^pins.host_data_bus, pins.host_data_bus};
    end else if (int_gnt && int_we_i) begin
      ram[i_idx] <= {^int_wdata_i, int_wdata_i};
    end
  end

  // read data registered on the same edge that ready falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_r <= '0;
    end else if (ce_i && state_r == DS_XFER && is_rd_r) begin
      if (is_mem_r) begin
        dout_r <= h_word[DW-1:0];
      end else begin
        case (addr_r[1:0])
          DREG_CFG:   dout_r <= {8'h00, cfg_r};
          DREG_STAT:  dout_r <= {8'h00, stat_r};
          DREG_MASK:  dout_r <= {8'h00, mask_r};
          default:    dout_r <= paddr_r;
        endcase
      end
    end
  end

  // internal port answers in the cycle after grant
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_ack_o   <= 1'b0;
      int_rdata_o <= '0;
    end else if (ce_i) begin
      int_ack_o <= int_gnt;
      if (int_gnt) begin
        int_rdata_o <= i_word[DW-1:0];
      end
    end
  end

  // ****************************************************************
  // registers, events and queue logging
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r  <= '0;
      mask_r <= '0;
    end else if (ce_i && state_r == DS_XFER && !is_mem_r && !is_rd_r) begin
      if (addr_r[1:0] == DREG_CFG) begin
        cfg_r <= pins.host_data_bus[7:0];
      end
      if (addr_r[1:0] == DREG_MASK) begin
        mask_r <= pins.host_data_bus[7:0];
      end
    end
  end

  // sticky status: a status read clears, a same-cycle event wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= '0;
    end else if (ce_i) begin
      if (state_r == DS_XFER && !is_mem_r && is_rd_r && addr_r[1:0] == DREG_STAT) begin
        stat_r <= '0;
      end
      if (perr) begin
        stat_r[EV_PARITY] <= 1'b1;
      end
    end
  end

  // parity error address capture and queue entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      paddr_r    <= '0;
      queue_wr_o <= 1'b0;
    end else if (ce_i) begin
      queue_wr_o <= perr && rt_mon_mode_i && cfg_r[CFG_QEN];
      if (perr) begin
        paddr_r <= h_perr ? addr_r : int_addr_i;
      end
    end
  end

  assign queue_addr_o = paddr_r;
  // six bits pick the 1k page of the housekeeping area
  assign hk_base_o    = {cfg_r[RELOC_W-1:0], HK_DEF_BASE[HK_SHIFT-1:0]};
  assign int_o        = |(stat_r & mask_r);
  assign pins.int_req_n            = !int_o;
  assign pins.dev_data_o           = dout_r;
  assign pins.dev_data_oe          = oe_r;
  assign pins.host_access_active_n = active_n_r;
  assign pins.transfer_ready_n     = ready_n_r;
endmodule : hsp_dev

// ==== hdl/hsp_host.sv ====
// host processor end: wishbone-programmed controller that runs one pin cycle
// assumes: wishbone classic master on the user side; device on the pins
`timescale 1ns/1ps
module hsp_host
  import hsp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  hsp_if.host              pins,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             int_o
);
  // ****************************************************************
  // registers
  // ****************************************************************
  hsp_hstate_e   state_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  logic          rd_r;
  logic          mem_r;
  logic          sel_n_r;
  logic          strb_n_r;
  logic          oe_r;
  logic          done_r;
  logic          mask_r;
  logic          wb_req;
  logic          wr_hit;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  assign wr_hit = wb_req && wb_we_i && wb_sel_i[0];

  // ****************************************************************
  // wishbone slave: one wait state, ack for one cycle
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      addr_r   <= '0;
      wdata_r  <= '0;
      mask_r   <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          HREG_ADDR:  wb_dat_o <= {16'h0000, addr_r};
          HREG_WDATA: wb_dat_o <= {16'h0000, wdata_r};
          HREG_STAT:  wb_dat_o <= {23'h000000, state_r != HS_IDLE, 7'h00, done_r};
          HREG_MASK:  wb_dat_o <= {31'h00000000, mask_r};
          HREG_RDATA: wb_dat_o <= {16'h0000, rdata_r};
          default:    wb_dat_o <= '0;
        endcase
      end
      if (wr_hit && wb_adr_i == HREG_ADDR && state_r == HS_IDLE) begin
        addr_r <= wb_dat_i[AW-1:0];
      end
      if (wr_hit && wb_adr_i == HREG_WDATA && state_r == HS_IDLE) begin
        wdata_r <= wb_dat_i[DW-1:0];
      end
      if (wr_hit && wb_adr_i == HREG_MASK) begin
        mask_r <= wb_dat_i[0];
      end
    end
  end

  // ****************************************************************
  // pin cycle sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r  <= HS_IDLE;
      sel_n_r  <= 1'b1;
      strb_n_r <= 1'b1;
      oe_r     <= 1'b0;
      rd_r     <= 1'b0;
      mem_r    <= 1'b0;
      rdata_r  <= '0;
    end else if (ce_i) begin
      case (state_r)
        HS_IDLE: begin
          if (wr_hit && wb_adr_i == HREG_CTRL && wb_dat_i[CTL_GO]) begin
            rd_r     <= wb_dat_i[CTL_RD];
            mem_r    <= wb_dat_i[CTL_MEM];
            oe_r     <= !wb_dat_i[CTL_RD];
            sel_n_r  <= 1'b0;
            strb_n_r <= 1'b0;
            state_r  <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!pins.host_access_active_n) begin
            sel_n_r <= 1'b1;
          end
          // address and mode stay put until ready, covering any extra clock
          if (!pins.transfer_ready_n) begin
            if (rd_r) begin
              rdata_r <= pins.host_data_bus;
            end
            strb_n_r <= 1'b1;
            sel_n_r  <= 1'b1;
            oe_r     <= 1'b0;
            state_r  <= HS_END;
          end
        end
        HS_END: begin
          if (pins.transfer_ready_n) begin
            state_r <= HS_IDLE;
          end
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  // done flag: set at end of a pin cycle, cleared by a status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r <= 1'b0;
    end else if (ce_i) begin
      if (wb_req && !wb_we_i && wb_adr_i == HREG_STAT) begin
        done_r <= 1'b0;
      end
      if (state_r == HS_WAIT && !pins.transfer_ready_n) begin
        done_r <= 1'b1;
      end
    end
  end

  assign int_o                       = done_r && mask_r;
  assign pins.select_n               = sel_n_r;
  assign pins.data_strobe_n          = strb_n_r;
  assign pins.mem_reg_sel            = mem_r;
  assign pins.rd_wr                  = rd_r ? STRAP_POL : !STRAP_POL;
  assign pins.host_address_bus       = addr_r;
  assign pins.host_data_o            = wdata_r;
  assign pins.host_data_oe           = oe_r;
  assign pins.address_latch_strobe   = 1'b1;
  assign pins.shared_ram_strap       = STRAP_SHARED;
  assign pins.no_wait_strap          = STRAP_NOWAIT;
  assign pins.dma_req_or_width_strap = STRAP_WIDTH;
  assign pins.polarity_strap         = STRAP_POL;
endmodule : hsp_host

// ==== verification/hsp_chk.sv ====
// checker: pin-level assertions between the host end and the terminal end
// assumes: instantiated beside the interface; one clock, sync reset high
`timescale 1ns/1ps
module hsp_chk
  import hsp_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          select_n,
  input wire logic          data_strobe_n,
  input wire logic          rd_wr,
  input wire logic          polarity_strap,
  input wire logic          host_access_active_n,
  input wire logic          transfer_ready_n,
  input wire logic          dev_data_oe,
  input wire logic          host_data_oe,
  input wire logic [DW-1:0] dev_data_o,
  input wire logic          address_latch_strobe,
  input wire logic          shared_ram_strap,
  input wire logic          no_wait_strap,
  input wire logic          dma_req_or_width_strap
);
  // ****************************************************************
  // pin assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  start_on_req_a: assert property ($fell(host_access_active_n)
    |-> $past(!select_n && !data_strobe_n)) else $error("active without request");
  ready_delay_a: assert property ($fell(host_access_active_n)
    |-> transfer_ready_n ##1 transfer_ready_n ##[1:3] !transfer_ready_n)
    else $error("ready latency wrong");
  ready_holds_a: assert property (!transfer_ready_n && !data_strobe_n
    |=> !transfer_ready_n) else $error("ready dropped early");
  cycle_release_a: assert property (!transfer_ready_n && data_strobe_n
    |=> transfer_ready_n && host_access_active_n && !dev_data_oe)
    else $error("cycle not released");
  read_sense_a: assert property ($rose(dev_data_oe)
    |-> rd_wr == polarity_strap && !transfer_ready_n) else $error("drive on write");
  data_stable_a: assert property (dev_data_oe && $past(dev_data_oe)
    |-> $stable(dev_data_o)) else $error("read data moved");
  no_bus_fight_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  strap_levels_a: assert property (!shared_ram_strap && no_wait_strap
    && dma_req_or_width_strap && address_latch_strobe) else $error("strap level wrong");
  // main scenarios
  cover property ($rose(dev_data_oe));
  cover property ($fell(transfer_ready_n) && !dev_data_oe);
  cover property ($fell(host_access_active_n) && select_n);
endmodule : hsp_chk

// ==== verification/host_shared_ram_port_tb.sv ====
// bench: host controller and terminal end joined by the pin interface
// assumes: wishbone and internal port driven here; data bus resolved here
`timescale 1ns/1ps
module host_shared_ram_port_tb;
  import hsp_pkg::*;
  // ****************************************************************
  // clock, pins and the two ends
  // ****************************************************************
  logic          clk_i = 0, rst_i = 1, cs = 0, we = 0, slip = 0, rt = 0, ce = 1;
  logic          ireq = 0, iwe = 0, wack, hint, dint, iack, qwr;
  logic [4:0]    adr = '0;
  logic [31:0]   wdat = '0, rdat;
  logic [AW-1:0] iadr = '0, hk, qadr;
  logic [DW-1:0] idat = '0, irdat, last = '0;
  int            miscompares = 0, check_count = 0, hold = 0, max_hold = 0, nq = 0;
  hsp_if i_hsp_if ();
  initial forever #10 clk_i = ~clk_i;
  // released bus shows the inverse of its last driven level
  assign i_hsp_if.host_data_bus = i_hsp_if.dev_data_oe ? i_hsp_if.dev_data_o
    : i_hsp_if.host_data_oe ? i_hsp_if.host_data_o : ~last;
  // last bus level, host holdoff length, queue entries
  always @(posedge clk_i) begin
    if (i_hsp_if.dev_data_oe || i_hsp_if.host_data_oe) last <= i_hsp_if.host_data_bus;
    hold <= (!i_hsp_if.select_n && i_hsp_if.host_access_active_n) ? hold + 1 : 0;
    if (hold > max_hold) max_hold <= hold;
    if (qwr === 1'b1) nq <= nq + 1;
  end
  hsp_dev #(.RAM_AW(6)) i_hsp_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .pins(i_hsp_if.dev), .sync_slip_i(slip), .rt_mon_mode_i(rt), .int_req_i(ireq),
    .int_we_i(iwe), .int_addr_i(iadr), .int_wdata_i(idat), .int_ack_o(iack),
    .int_rdata_o(irdat), .queue_wr_o(qwr), .queue_addr_o(qadr), .hk_base_o(hk),
    .int_o(dint));
  hsp_host i_hsp_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pins(i_hsp_if.host),
    .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(wack), .int_o(hint));
  hsp_chk i_hsp_chk (.clk_i(clk_i), .rst_i(rst_i), .select_n(i_hsp_if.select_n),
    .data_strobe_n(i_hsp_if.data_strobe_n), .rd_wr(i_hsp_if.rd_wr),
    .polarity_strap(i_hsp_if.polarity_strap),
    .host_access_active_n(i_hsp_if.host_access_active_n),
    .transfer_ready_n(i_hsp_if.transfer_ready_n), .dev_data_oe(i_hsp_if.dev_data_oe),
    .host_data_oe(i_hsp_if.host_data_oe), .dev_data_o(i_hsp_if.dev_data_o),
    .address_latch_strobe(i_hsp_if.address_latch_strobe),
    .shared_ram_strap(i_hsp_if.shared_ram_strap), .no_wait_strap(i_hsp_if.no_wait_strap),
    .dma_req_or_width_strap(i_hsp_if.dma_req_or_width_strap));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait ran out: count it and close the run
  task automatic hang(input string what);
    chk(what, 1, 0);
    give_verdict();
  endtask : hang
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cs <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wack !== 1'b1 && n < 50);
    q = rdat;
    cs <= 0;
    if (n >= 50) hang("wb ack");
  endtask : wb
  // one pin transfer through the host controller
  task automatic pin(input logic rd, mem, input logic [15:0] a, d, output logic [15:0] q);
    logic [31:0] s;
    int          n;
    logic        seen;
    wb(1, HREG_ADDR, {16'h0, a}, s);
    wb(1, HREG_WDATA, {16'h0, d}, s);
    wb(1, HREG_CTRL, {29'h0, mem, rd, 1'b1}, s);
    seen = 0;
    n = 0;
    do begin
      wb(0, HREG_STAT, '0, s);
      seen = seen | (s[0] === 1'b1);
      n++;
    end while ((!seen || s[ST_BUSY] !== 1'b0) && n < 40);
    if (n >= 40) hang("pin done");
    wb(0, HREG_RDATA, '0, s);
    q = s[15:0];
  endtask : pin
  // one internal ram access, request held until ack is sampled
  task automatic intx(input logic w, input logic [15:0] a, d, output logic [15:0] q);
    int n;
    @(posedge clk_i);
    ireq <= 1;
    iwe <= w;
    iadr <= a;
    idat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (iack !== 1'b1 && n < 50);
    q = irdat;
    ireq <= 0;
    if (n >= 50) hang("int ack");
  endtask : intx
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [15:0] q;
    chk("active_n", 1, i_hsp_if.host_access_active_n);
    chk("hk base", HK_DEF_BASE, hk);
    pin(1, 0, {14'h0, DREG_CFG}, '0, q);
    chk("cfg", 0, q);
  endtask : t_reset
  task automatic t_ram();
    logic [15:0] q;
    pin(0, 1, 16'h0005, 16'h1234, q);
    pin(0, 1, 16'h0002, 16'haaaa, q);
    pin(0, 0, {14'h0, DREG_MASK}, 16'h0001, q);
    pin(1, 1, 16'h0005, '0, q);
    chk("ram 5", 16'h1234, q);
    pin(1, 1, 16'h0002, '0, q);
    chk("ram 2", 16'haaaa, q);
    pin(1, 0, {14'h0, DREG_MASK}, '0, q);
    chk("mask", 1, q);
    pin(1, 0, {14'h0, DREG_STAT}, '0, q);
    chk("parity status", 0, q);
    chk("int req", 1, i_hsp_if.int_req_n);
  endtask : t_ram
  task automatic t_reloc_slip();
    logic [15:0] q;
    pin(0, 0, {14'h0, DREG_CFG}, 16'h002a, q);
    chk("hk base", 16'ha800, hk);
    slip <= 1;
    pin(0, 1, 16'h0007, 16'h0f0f, q);
    pin(1, 1, 16'h0007, '0, q);
    chk("slip read", 16'h0f0f, q);
    slip <= 0;
  endtask : t_reloc_slip
  task automatic t_contend();
    logic [15:0] q, r;
    pin(0, 0, {14'h0, DREG_CFG}, 16'h00c0, q);
    rt <= 1;
    fork
      pin(0, 1, 16'h000a, 16'hc3c3, q);
      repeat (12) intx(1, 16'h0009, 16'h5a5a, r);
    join
    chk("holdoff", 1, max_hold <= 1);
    pin(1, 1, 16'h0009, '0, q);
    chk("int write", 16'h5a5a, q);
    intx(0, 16'h000a, '0, r);
    chk("int read", 16'hc3c3, r);
    chk("queue", 0, nq);
  endtask : t_contend
  // device enable low: the host request waits, nothing moves, then it completes
  task automatic t_freeze();
    logic [15:0] q;
    ce <= 0;
    fork
      pin(1, 1, 16'h0005, '0, q);
      begin
        repeat (30) @(posedge clk_i);
        chk("frozen active_n", 1, i_hsp_if.host_access_active_n);
        chk("frozen ready_n", 1, i_hsp_if.transfer_ready_n);
        ce <= 1;
      end
    join
    chk("ram 5 after freeze", 16'h1234, q);
  endtask : t_freeze
  task automatic t_hint();
    logic [31:0] s;
    int          n;
    wb(0, 5'h18, '0, s);
    chk("unmapped", 0, s);
    wb(1, HREG_MASK, 1, s);
    wb(1, HREG_CTRL, 32'h3, s);
    n = 0;
    while (hint !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("host int set", 1, hint);
    wb(0, HREG_STAT, '0, s);
    @(posedge clk_i);
    chk("host int clear", 0, hint);
  endtask : t_hint
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_reset();
    t_ram();
    t_reloc_slip();
    t_contend();
    t_freeze();
    t_hint();
    give_verdict();
  end
endmodule : host_shared_ram_port_tb
